// file: core/program_flow_control_unit.sv
// Program-flow control unit: redirects, calls, exceptions and system operations.
//
// Functional notes
// - Taken transfers redirect fetch, no delay slot.
// - Immediate call: absolute target, link register written.
// - Register call: target from register, link written.
// - Return loads program counter from link register.
// - Register jump leaves link register untouched.
// - Immediate jump saves no return address.
// - Relative jump adds signed offset to pc.
// - Conditional branches compare two registers.
// - Trap saves status, resume address, vectors.
// - Exception exit restores status, resumes saved address.
// - Debug break entry and exit supported.
// - Control moves between control and general registers.
// - Cache operations forwarded to cache control.
// - Prefetch flush discards all fetched instructions.
// - Ordering barrier holds later loads and stores.
// - Cross-set moves read or write other sets.
// - Cross-set write may store zero in register zero.
// - Custom instruction dispatches operands, returns result.
// - No-operation changes no architectural state.
// - Branch relations match compare instructions.
`timescale 1ns/10ps
module program_flow_control_unit
  import flow_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire decode_t     dec,
  output logic             dec_ready,
  input  wire logic        mem_idle,
  input  wire logic [31:0] prs_rdata,
  input  wire logic        cust_done,
  input  wire logic [31:0] cust_result,
  output fetch_cmd_t       fetch_o,
  output rf_wr_t           rf_o,
  output prs_cmd_t         prs_o,
  output cache_cmd_t       cache_o,
  output cust_cmd_t        cust_o,
  output logic             ldst_hold,
  output logic [31:0]      status_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  // Multi-cycle operations park here until their partner answers.
  typedef enum logic [1:0] {
    ST_RUN, ST_SYNC, ST_PRS, ST_CUST
  } flow_st_t;

  // Registered state of the unit outside ctl_regs; every output but status_o comes from it.
  typedef struct packed {
    flow_st_t    st;
    logic [4:0]  rd;
    fetch_cmd_t  fetch;
    rf_wr_t      rf;
    prs_cmd_t    prs;
    cache_cmd_t  cache;
    cust_cmd_t   cust;
  } unit_state_t;

  unit_state_t s_q;       // Registered state.
  unit_state_t s_d;       // Next state.

  logic        cond;       // Relation holds for a conditional branch.
  logic        is_cond;    // Operation is a conditional branch.
  logic [31:0] next_pc;    // Address of the following instruction.
  logic [31:0] rel_tgt;    // Relative target for branches.
  logic [31:0] ctl_rdata;  // Control register read data.
  logic [31:0] resume_exc; // Saved exception resume address.
  logic [31:0] resume_brk; // Saved break resume address.
  logic        take;       // Decoder instruction accepted this cycle.
  logic        exc_enter;  // Trap accepted.
  logic        exc_exit;   // Exception exit accepted.
  logic        brk_enter;  // Break accepted.
  logic        brk_exit;   // Break exit accepted.
  logic        ctl_wr;     // Control register write accepted.

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Accept a new instruction only when no multi-cycle operation is parked.
  assign dec_ready = (s_q.st == ST_RUN);
  assign take      = dec.valid && dec_ready && ce;

  // Following address, saved by calls and trap.
  assign next_pc = dec.pc + INSN_BYTES;
  // Relative target from the instruction's own position.
  assign rel_tgt = dec.pc + dec.imm;

  assign exc_enter = take && dec.op == OP_TRAP;
  assign exc_exit  = take && dec.op == OP_ERET;
  assign brk_enter = take && dec.op == OP_BREAK;
  assign brk_exit  = take && dec.op == OP_BRET;
  assign ctl_wr    = take && dec.op == OP_WRCTL;

  // Relation evaluation for conditional branches.
  branch_compare u_cmp (
    .op      (dec.op),
    .a       (dec.a),
    .b       (dec.b),
    .cond    (cond),
    .is_cond (is_cond)
  );

  // Status, saved status and resume registers.
  ctl_regs u_ctl (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .exc_enter  (exc_enter),
    .exc_exit   (exc_exit),
    .brk_enter  (brk_enter),
    .brk_exit   (brk_exit),
    .ret_addr   (next_pc),
    .wr_en      (ctl_wr),
    .wr_idx     (dec.ctl),
    .wr_data    (dec.a),
    .rd_idx     (dec.ctl),
    .rd_data    (ctl_rdata),
    .status     (status_o),
    .resume_exc (resume_exc),
    .resume_brk (resume_brk)
  );

  // Load a redirect; every redirect also kills the younger instructions.
  function automatic fetch_cmd_t go(input logic [31:0] tgt);
    fetch_cmd_t f;
    f.redirect = 1'b1;
    f.target   = tgt;
    f.flush    = 1'b1;
    return f;
  endfunction : go

  // Write into the general register file.
  function automatic rf_wr_t wr(input logic [4:0] idx, input logic [31:0] d);
    rf_wr_t w;
    w.we   = 1'b1;
    w.idx  = idx;
    w.data = d;
    return w;
  endfunction : wr

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Commands are one-cycle pulses; they are cleared every cycle and set below.
  always_comb begin
    s_d          = s_q;
    s_d.fetch    = '0;
    s_d.rf       = '0;
    s_d.prs      = '0;
    s_d.cache    = '0;
    s_d.cust     = '0;
    unique case (s_q.st)
      ST_RUN: begin
        if (take) begin
          unique case (dec.op)
            OP_CALL: begin
              s_d.fetch = go(dec.imm);
              s_d.rf    = wr(LINK_REG, next_pc);
            end
            OP_CALLR: begin
              s_d.fetch = go(dec.a);
              s_d.rf    = wr(LINK_REG, next_pc);
            end
            // The decoder presents the link register value on operand a.
            OP_RET:   s_d.fetch = go(dec.a);
            OP_JMP:   s_d.fetch = go(dec.a);
            OP_JMPI:  s_d.fetch = go(dec.imm);
            OP_BR:    s_d.fetch = go(rel_tgt);
            OP_BEQ, OP_BNE, OP_BLT, OP_BLTU, OP_BLE, OP_BLEU,
            OP_BGT, OP_BGTU, OP_BGE, OP_BGEU: begin
              // Not taken: the next sequential instruction just flows on.
              if (is_cond && cond) begin
                s_d.fetch = go(rel_tgt);
              end
            end
            OP_TRAP:  s_d.fetch = go(EXC_VECTOR);
            OP_ERET:  s_d.fetch = go(resume_exc);
            OP_BREAK: s_d.fetch = go(BRK_VECTOR);
            OP_BRET:  s_d.fetch = go(resume_brk);
            OP_RDCTL: s_d.rf = wr(dec.rd, ctl_rdata);
            OP_WRCTL: begin
              // Status writes may change interrupt enable, so refetch.
              s_d.fetch = go(next_pc);
            end
            OP_CACHE_D: begin
              s_d.cache.dcache = 1'b1;
              s_d.cache.addr   = dec.a + dec.imm;
            end
            OP_CACHE_I: begin
              s_d.cache.icache = 1'b1;
              s_d.cache.addr   = dec.a + dec.imm;
              s_d.fetch        = go(next_pc);
            end
            OP_FLUSHP: s_d.fetch = go(next_pc);
            OP_SYNC: begin
              s_d.st = ST_SYNC;
            end
            OP_RDPRS: begin
              s_d.prs.rd_en = 1'b1;
              s_d.prs.set   = dec.set;
              s_d.prs.idx   = dec.ctl;
              s_d.rd        = dec.rd;
              s_d.st        = ST_PRS;
            end
            OP_WRPRS: begin
              // Register zero of a shadow set is writable, zero included.
              s_d.prs.wr_en = 1'b1;
              s_d.prs.set   = dec.set;
              s_d.prs.idx   = dec.rd;
              s_d.prs.data  = dec.a;
            end
            OP_CUSTOM: begin
              s_d.cust = '{start: 1'b1, a: dec.a, b: dec.b};
              s_d.rd   = dec.rd;
              s_d.st   = ST_CUST;
            end
            OP_NOP: s_d = s_d;
            default: s_d = s_d;
          endcase
        end
      end
      ST_SYNC: begin
        // Wait for outstanding memory work before releasing loads and stores.
        if (ce && mem_idle) begin
          s_d.st = ST_RUN;
        end
      end
      ST_PRS: begin
        // Other-set read data arrive in the cycle the request stands on prs_o.
        if (ce) begin
          s_d.rf = wr(s_q.rd, prs_rdata);
          s_d.st = ST_RUN;
        end
      end
      ST_CUST: begin
        if (ce && cust_done) begin
          s_d.rf = wr(s_q.rd, cust_result);
          s_d.st = ST_RUN;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; the clock enable freezes everything.

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{st: ST_RUN, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs come from the registered state.
  assign fetch_o   = s_q.fetch;
  assign rf_o      = s_q.rf;
  assign prs_o     = s_q.prs;
  assign cache_o   = s_q.cache;
  assign cust_o    = s_q.cust;
  // Loads and stores held while the barrier waits.
  assign ldst_hold = (s_q.st == ST_SYNC);

endmodule : program_flow_control_unit

// file: core/flow_pkg.sv
// Package with the types and constants shared by the program-flow control unit.
package flow_pkg;

  // Width of addresses and data words.
  localparam int unsigned XLEN        = 32;
  // Width of a register index.
  localparam int unsigned RIDX        = 5;
  // Size of one instruction in bytes, used to form the next address.
  localparam logic [31:0] INSN_BYTES  = 32'h0000_0004;
  // Index of the link register in the general register file.
  localparam logic [4:0]  LINK_REG    = 5'h1f;
  // Reset value of the program counter.
  localparam logic [31:0] RESET_PC    = 32'h0000_0000;
  // Reset value of the status register.
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  // Address of the general exception handler.
  localparam logic [31:0] EXC_VECTOR  = 32'h0000_0020;
  // Address of the debug break handler.
  localparam logic [31:0] BRK_VECTOR  = 32'h0000_0100;
  // Position of the interrupt enable bit in the status register.
  localparam int unsigned STATUS_IE   = 0;
  // Control register indices handled locally.
  localparam logic [4:0]  CR_STATUS   = 5'h00;
  localparam logic [4:0]  CR_ESTATUS  = 5'h01;
  localparam logic [4:0]  CR_BSTATUS  = 5'h02;
  // Settle cycles for an ordering barrier after the memory goes idle; unused, the barrier ends at the first edge with mem_idle.
  localparam int unsigned SYNC_SETTLE = 1;

  // Decoded operation classes presented by the decoder.
  typedef enum logic [4:0] {
    OP_NOP, OP_CALL, OP_CALLR, OP_RET, OP_JMP, OP_JMPI, OP_BR,
    OP_BEQ, OP_BNE, OP_BLT, OP_BLTU, OP_BLE, OP_BLEU, OP_BGT, OP_BGTU,
    OP_BGE, OP_BGEU, OP_TRAP, OP_ERET, OP_BREAK, OP_BRET, OP_RDCTL,
    OP_WRCTL, OP_CACHE_D, OP_CACHE_I, OP_FLUSHP, OP_SYNC, OP_RDPRS,
    OP_WRPRS, OP_CUSTOM
  } flow_op_t;

  // One decoded instruction from the decoder.
  typedef struct packed {
    logic        valid;  // Instruction present this cycle.
    flow_op_t    op;     // Operation class.
    logic [31:0] pc;     // Address of this instruction.
    logic [31:0] imm;    // Immediate, already extended by the decoder.
    logic [31:0] a;      // First source register value.
    logic [31:0] b;      // Second source register value.
    logic [4:0]  rd;     // Destination register index.
    logic [4:0]  ctl;    // Control register or cross-set register index.
    logic [3:0]  set;    // Target register set for cross-set moves.
  } decode_t;

  // Redirect command towards fetch.
  typedef struct packed {
    logic        redirect; // Load the program counter this cycle.
    logic [31:0] target;   // New fetch address.
    logic        flush;    // Kill every younger instruction in flight.
  } fetch_cmd_t;

  // Register file write port.
  typedef struct packed {
    logic        we;
    logic [4:0]  idx;
    logic [31:0] data;
  } rf_wr_t;

  // Cross-set register access.
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [3:0]  set;
    logic [4:0]  idx;
    logic [31:0] data;
  } prs_cmd_t;

  // Cache maintenance command.
  typedef struct packed {
    logic        dcache;
    logic        icache;
    logic [31:0] addr;
  } cache_cmd_t;

  // Custom instruction dispatch.
  typedef struct packed {
    logic        start;
    logic [31:0] a;
    logic [31:0] b;
  } cust_cmd_t;

endpackage : flow_pkg

// file: core/branch_compare.sv
// Comparator that decides whether a conditional branch is taken.
`timescale 1ns/10ps
module branch_compare
  import flow_pkg::*;
(
  input  wire flow_op_t    op,
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic             cond,
  output logic             is_cond
);

  // Equality and signed and unsigned less-than feed the relations, as the compare ops do.
  logic lt_s;  // Signed a < b.
  logic lt_u;  // Unsigned a < b.
  logic eq;    // a == b.

  assign lt_s = $signed(a) < $signed(b);
  assign lt_u = a < b;
  assign eq   = a == b;

  // Evaluate the relation named by the operation.
  always_comb begin
    cond    = 1'b0;
    is_cond = 1'b1;
    unique case (op)
      OP_BEQ:  cond = eq;
      OP_BNE:  cond = !eq;
      OP_BLT:  cond = lt_s;
      OP_BLTU: cond = lt_u;
      OP_BLE:  cond = lt_s || eq;
      OP_BLEU: cond = lt_u || eq;
      OP_BGT:  cond = !(lt_s || eq);
      OP_BGTU: cond = !(lt_u || eq);
      OP_BGE:  cond = !lt_s;
      OP_BGEU: cond = !lt_u;
      default: is_cond = 1'b0;
    endcase
  end

endmodule : branch_compare

// file: core/ctl_regs.sv
// Status, saved-status and resume registers of the flow unit.
`timescale 1ns/10ps
module ctl_regs
  import flow_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        exc_enter,
  input  wire logic        exc_exit,
  input  wire logic        brk_enter,
  input  wire logic        brk_exit,
  input  wire logic [31:0] ret_addr,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [4:0]  rd_idx,
  output logic [31:0]      rd_data,
  output logic [31:0]      status,
  output logic [31:0]      resume_exc,
  output logic [31:0]      resume_brk
);

  // All state of this module.
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] estatus;
    logic [31:0] bstatus;
    logic [31:0] exception_resume_register;
    logic [31:0] brk_resume;
  } ctl_state_t;

  ctl_state_t s_q;  // Registered state.
  ctl_state_t s_d;  // Next state.

  // Entry and exit save or restore status; entry also clears interrupt enable.
  always_comb begin
    s_d = s_q;
    if (exc_enter) begin
      s_d.estatus                   = s_q.status;
      s_d.exception_resume_register = ret_addr;
      s_d.status[STATUS_IE]         = 1'b0;
    end else if (exc_exit) begin
      s_d.status = s_q.estatus;
    end else if (brk_enter) begin
      s_d.bstatus           = s_q.status;
      s_d.brk_resume        = ret_addr;
      s_d.status[STATUS_IE] = 1'b0;
    end else if (brk_exit) begin
      s_d.status = s_q.bstatus;
    end else if (wr_en) begin
      // Other indices belong to logic outside this unit.
      unique case (wr_idx)
        CR_STATUS:  s_d.status  = wr_data;
        CR_ESTATUS: s_d.estatus = wr_data;
        CR_BSTATUS: s_d.bstatus = wr_data;
        default:    s_d = s_q;
      endcase
    end
  end

  // Register the state while enabled.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{status: STATUS_RST, estatus: STATUS_RST, bstatus: STATUS_RST,
               exception_resume_register: RESET_PC, brk_resume: RESET_PC};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Read mux for control register reads.
  always_comb begin
    unique case (rd_idx)
      CR_STATUS:  rd_data = s_q.status;
      CR_ESTATUS: rd_data = s_q.estatus;
      CR_BSTATUS: rd_data = s_q.bstatus;
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  assign status     = s_q.status;
  assign resume_exc = s_q.exception_resume_register;
  assign resume_brk = s_q.brk_resume;

endmodule : ctl_regs

// file: tb/flow_monitor.sv
// Concurrent checks on the ports of the program-flow control unit.
`timescale 1ns/10ps
module flow_monitor
  import flow_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire decode_t     dec,
  input wire logic        dec_ready,
  input wire logic        mem_idle,
  input wire logic [31:0] prs_rdata,
  input wire logic        cust_done,
  input wire logic [31:0] cust_result,
  input wire fetch_cmd_t  fetch_o,
  input wire rf_wr_t      rf_o,
  input wire prs_cmd_t    prs_o,
  input wire cache_cmd_t  cache_o,
  input wire cust_cmd_t   cust_o,
  input wire logic        ldst_hold,
  input wire logic [31:0] status_o
);
  // High at an edge where the unit accepts an instruction.
  logic tk;
  assign tk = dec.valid && dec_ready && ce;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  a_call_link: assert property (tk && dec.op == OP_CALL |=> fetch_o.redirect
    && fetch_o.target == $past(dec.imm) && rf_o.we && rf_o.idx == LINK_REG
    && rf_o.data == $past(dec.pc) + INSN_BYTES) else $error("call target or link wrong");
  a_callr_link: assert property (tk && dec.op == OP_CALLR |=> fetch_o.redirect
    && fetch_o.target == $past(dec.a) && rf_o.we && rf_o.idx == LINK_REG)
    else $error("register call wrong");
  a_jmp_nolink: assert property (tk && dec.op == OP_JMP |=> fetch_o.redirect
    && fetch_o.target == $past(dec.a) && !rf_o.we) else $error("register jump wrong");
  a_rel_target: assert property (tk && dec.op == OP_BR |=> fetch_o.redirect
    && fetch_o.target == $past(dec.pc) + $past(dec.imm)) else $error("relative jump wrong");
  a_trap_vector: assert property (tk && dec.op == OP_TRAP |=> fetch_o.redirect
    && fetch_o.target == EXC_VECTOR && !status_o[STATUS_IE]) else $error("trap entry wrong");
  a_nop_quiet: assert property (tk && dec.op == OP_NOP |=> !fetch_o.redirect
    && !rf_o.we && !prs_o.wr_en && $stable(status_o)) else $error("nop changed state");
  a_redirect_flush: assert property (fetch_o.redirect |-> fetch_o.flush)
    else $error("redirect without flush");
  a_sync_hold: assert property (tk && dec.op == OP_SYNC |=> ldst_hold)
    else $error("barrier not held");
  a_hold_blocks: assert property (ldst_hold |-> !dec_ready)
    else $error("ready during barrier");
  a_hold_ends: assert property (ldst_hold && mem_idle && ce |-> ##[1:2] !ldst_hold)
    else $error("barrier not released");
  a_prs_write: assert property (tk && dec.op == OP_WRPRS |=> prs_o.wr_en
    && prs_o.idx == $past(dec.rd) && prs_o.set == $past(dec.set)
    && prs_o.data == $past(dec.a)) else $error("set write wrong");
endmodule : flow_monitor

bind program_flow_control_unit flow_monitor mon_u (.clk(clk), .nrst(nrst), .ce(ce),
  .dec(dec), .dec_ready(dec_ready), .mem_idle(mem_idle), .prs_rdata(prs_rdata),
  .cust_done(cust_done), .cust_result(cust_result), .fetch_o(fetch_o), .rf_o(rf_o),
  .prs_o(prs_o), .cache_o(cache_o), .cust_o(cust_o), .ldst_hold(ldst_hold),
  .status_o(status_o));

// file: tb/far_side_model.sv
// Model of memory, other register sets and custom logic beside the unit.
`timescale 1ns/10ps
module far_side_model
  import flow_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        slow,
  input wire prs_cmd_t    prs_o,
  input wire cust_cmd_t   cust_o,
  input wire logic        ldst_hold,
  output logic            mem_idle,
  output logic [31:0]     prs_rdata,
  output logic            cust_done,
  output logic [31:0]     cust_result
);
  logic [2:0] mem_cnt_q;  // Cycles the memory stays busy.
  logic       hold_q;     // Barrier level one cycle ago.
  logic [2:0] cust_cnt_q; // Cycles until the custom result is ready.
  logic       hold_rise;  // Barrier just began while memory is slow.
  logic [31:0] noise_q;   // Junk shown on the read bus when no read stands.

  // A slow memory is still busy when the barrier starts, so it must wait.
  assign hold_rise = ldst_hold && !hold_q && slow;
  assign mem_idle = (mem_cnt_q == 3'h0) && !hold_rise;
  assign cust_done = (cust_cnt_q == 3'h1);
  // Read data answer in the cycle the request stands; otherwise junk shows.
  assign prs_rdata = prs_o.rd_en ? (32'ha5a5_0000 | {23'h0, prs_o.set, prs_o.idx})
                                 : noise_q;

  // Memory, barrier and custom logic timing; the junk word toggles each cycle.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_cnt_q <= 3'h0;
      hold_q <= 1'b0;
      cust_cnt_q <= 3'h0;
      noise_q <= 32'h0;
      cust_result <= 32'h0;
    end else begin
      hold_q <= ldst_hold;
      if (hold_rise) mem_cnt_q <= 3'h3;
      else if (mem_cnt_q != 3'h0) mem_cnt_q <= mem_cnt_q - 3'h1;
      noise_q <= ~noise_q;
      if (cust_o.start) begin
        cust_cnt_q <= slow ? 3'h4 : 3'h1;
        cust_result <= cust_o.a + cust_o.b;
      end else begin
        if (cust_cnt_q != 3'h0) cust_cnt_q <= cust_cnt_q - 3'h1;
        if (cust_done) cust_result <= ~cust_result;
      end
    end
  end
endmodule : far_side_model

// file: tb/tb.sv
// Self-checking bench for the program-flow control unit.
`timescale 1ns/10ps
module tb;
  import flow_pkg::*;
  localparam logic [31:0] PC = 32'h100; // Address of every issued instruction.
  typedef struct packed {
    flow_op_t    op;
    logic [31:0] a;
    logic [31:0] b;
    logic        tk;
  } row_t;
  // Each relation at a boundary: BEQ and BNE taken and not taken, the others one way only.
  row_t rows [12] = '{
    '{OP_BEQ, 32'h5, 32'h5, 1'b1}, '{OP_BEQ, 32'h5, 32'h6, 1'b0},
    '{OP_BNE, 32'h5, 32'h6, 1'b1}, '{OP_BNE, 32'h7, 32'h7, 1'b0},
    '{OP_BLT, 32'hffffffff, 32'h1, 1'b1}, '{OP_BLTU, 32'hffffffff, 32'h1, 1'b0},
    '{OP_BLE, 32'h3, 32'h3, 1'b1}, '{OP_BLEU, 32'h80000000, 32'h1, 1'b0},
    '{OP_BGT, 32'h1, 32'hffffffff, 1'b1}, '{OP_BGTU, 32'h1, 32'hffffffff, 1'b0},
    '{OP_BGE, 32'h80000000, 32'h0, 1'b0}, '{OP_BGEU, 32'h80000000, 32'h0, 1'b1}};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        slow = 1'b0;
  decode_t     dec = '0;
  logic        dec_ready, mem_idle, cust_done, ldst_hold;
  logic [31:0] prs_rdata, cust_result, status_o;
  fetch_cmd_t  fetch_o;
  rf_wr_t      rf_o;
  prs_cmd_t    prs_o;
  cache_cmd_t  cache_o;
  cust_cmd_t   cust_o;
  int          failures = 0;
  int          n_checks = 0;

  always #25 clk = ~clk;

  program_flow_control_unit dut_u (.clk(clk), .nrst(nrst), .ce(ce), .dec(dec),
    .dec_ready(dec_ready), .mem_idle(mem_idle), .prs_rdata(prs_rdata),
    .cust_done(cust_done), .cust_result(cust_result), .fetch_o(fetch_o), .rf_o(rf_o),
    .prs_o(prs_o), .cache_o(cache_o), .cust_o(cust_o), .ldst_hold(ldst_hold),
    .status_o(status_o));
  far_side_model far_u (.clk(clk), .nrst(nrst), .slow(slow), .prs_o(prs_o),
    .cust_o(cust_o), .ldst_hold(ldst_hold), .mem_idle(mem_idle), .prs_rdata(prs_rdata),
    .cust_done(cust_done), .cust_result(cust_result));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Issues one instruction; returns at the falling edge of the answer cycle.
  // A cross-set write names its target register through ctl as well.
  task automatic go(input flow_op_t op, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] imm, input logic [4:0] ctl);
    @(negedge clk);
    dec <= '{1'b1, op, PC, imm, a, b, (op == OP_WRPRS) ? ctl : 5'h03, ctl, 4'h2};
    @(negedge clk);
    dec.valid <= 1'b0;
  endtask : go

  // Waits a bounded time for a register file write.
  task automatic wait_we;
    for (int k = 0; k < 8 && rf_o.we !== 1'b1; k++) @(negedge clk);
  endtask : wait_we

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // A hang counts as a mismatch; the tests need about a hundred cycles.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk(status_o, STATUS_RST);
    chk({ldst_hold, dec_ready, fetch_o.redirect, rf_o.we}, 32'h4);
    // Every relation, taken to pc plus offset or not taken at all.
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].a, rows[i].b, 32'h40, 5'h0);
      chk(fetch_o.redirect, rows[i].tk);
      if (rows[i].tk) chk(fetch_o.target, PC + 32'h40);
    end
    go(OP_CALL, 32'h0, 32'h0, 32'h2000, 5'h0);
    chk(fetch_o.target, 32'h2000);
    chk({rf_o.we, rf_o.idx, rf_o.data}, {1'b1, LINK_REG, PC + INSN_BYTES});
    go(OP_CALLR, 32'h3000, 32'h0, 32'h0, 5'h0);
    chk({rf_o.we, fetch_o.target}, {1'b1, 32'h3000});
    go(OP_RET, 32'h104, 32'h0, 32'h0, 5'h0);
    chk(fetch_o.target, 32'h104);
    go(OP_JMP, 32'h4000, 32'h0, 32'h0, 5'h0);
    chk({rf_o.we, fetch_o.target}, {1'b0, 32'h4000});
    go(OP_JMPI, 32'h0, 32'h0, 32'h5000, 5'h0);
    chk({rf_o.we, fetch_o.target}, {1'b0, 32'h5000});
    go(OP_BR, 32'h0, 32'h0, 32'hfffffff0, 5'h0);
    chk(fetch_o.target, 32'hf0);
    go(OP_NOP, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.redirect, rf_o.we, prs_o.wr_en}, 32'h0);
    go(OP_WRCTL, 32'h1, 32'h1, 32'h0, CR_STATUS);
    chk(status_o, 32'h1);
    go(OP_RDCTL, 32'h0, 32'h0, 32'h0, CR_STATUS);
    chk({rf_o.we, rf_o.idx, rf_o.data}, {1'b1, 5'h03, 32'h1});
    go(OP_TRAP, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.target, status_o}, {EXC_VECTOR, 32'h0});
    go(OP_RDCTL, 32'h0, 32'h0, 32'h0, CR_ESTATUS);
    chk(rf_o.data, 32'h1);
    go(OP_ERET, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.target, status_o}, {PC + INSN_BYTES, 32'h1});
    go(OP_BREAK, 32'h0, 32'h0, 32'h0, 5'h0);
    chk(fetch_o.target, BRK_VECTOR);
    go(OP_BRET, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.target, status_o}, {PC + INSN_BYTES, 32'h1});
    go(OP_CACHE_D, 32'h1000, 32'h0, 32'h8, 5'h0);
    chk({cache_o.dcache, cache_o.icache, cache_o.addr}, {2'b10, 32'h1008});
    go(OP_CACHE_I, 32'h1000, 32'h0, 32'h8, 5'h0);
    chk({cache_o.icache, fetch_o.redirect}, 32'h3);
    go(OP_FLUSHP, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.flush, fetch_o.target}, {1'b1, PC + INSN_BYTES});
    // Zero into register zero of set two.
    go(OP_WRPRS, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({prs_o.wr_en, prs_o.set, prs_o.idx, prs_o.data}, {10'h240, 32'h0});
    go(OP_RDPRS, 32'h0, 32'h0, 32'h0, 5'h07);
    chk({prs_o.rd_en, prs_o.set, prs_o.idx}, 32'h247);
    wait_we();
    chk({rf_o.we, rf_o.data}, {1'b1, 32'ha5a5_0047});
    slow = 1'b1;
    go(OP_CUSTOM, 32'h7, 32'h8, 32'h0, 5'h0);
    chk({cust_o.start, cust_o.a}, {1'b1, 32'h7});
    wait_we();
    chk({rf_o.we, rf_o.data}, {1'b1, 32'hf});
    go(OP_SYNC, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({ldst_hold, dec_ready}, 32'h2);
    for (int k = 0; k < 8 && ldst_hold !== 1'b0; k++) @(negedge clk);
    chk({ldst_hold, dec_ready}, 32'h1);
    // A frozen unit takes nothing and keeps its status.
    ce = 1'b0;
    go(OP_TRAP, 32'h0, 32'h0, 32'h0, 5'h0);
    chk({fetch_o.redirect, status_o}, {1'b0, 32'h1});
    ce = 1'b1;
    // A reset in mid-run brings the unit back to idle.
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk({status_o, ldst_hold, dec_ready}, {STATUS_RST, 2'b01});
    tally_and_finish();
  end
endmodule : tb
